/* File: sciflg_pkg.sv */
// Package with constants and carrier types for the serial status flag block
// Function
// - Enabling the transmitter sets both the data-empty and the complete flag.
// - The data-empty flag requests an interrupt only while its mask is one.
// - The complete flag requests an interrupt only while its mask is one.
// - Hardware sets each flag and only the normal servicing clear sequence clears it; each accepted character also rewrites noise and framing.
// - Clearing the enable lets the character being shifted finish first.
// - Only device reset stops the transmitter at once; disabling never aborts.
// - Disabling while idle hands the pin back to port use on a bit-rate tick.
// - Disabling mid-character drops any character still queued.
// - The last character's end sets complete and data-empty even when disabled.
// - A character moved into the receive register sets the data-full flag.
// - A character arriving before the last was read is lost and sets overrun.
// - Noise and framing flags describe the held character and never interrupt.
// - Idle sets once when the line, after being busy, stays high a character time.
// - The receiver has five readable flags of which three can interrupt.
package sciflg_pkg;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned IDLE_W      = 4;
    localparam logic [3:0]  IDLE_BITS   = 4'ha;  // Bit times in one character
    localparam logic [3:0]  IDLE_ZERO   = 4'h0;
    localparam logic        TX_DATA_EMPTY_FLAG_RST    = 1'b1;
    localparam logic        TC_RST      = 1'b1;
    localparam logic [7:0]  DATA_RST    = 8'h00;

    // Control bits written by software
    typedef struct packed {
        logic tx_enable;
        logic tx_empty_irq_mask;
        logic tx_complete_irq_mask;
        logic rx_irq_enable;
        logic idle_irq_enable;
    } sciflg_ctrl_t;

    // Status flags read by software
    typedef struct packed {
        logic tx_data_empty_flag;
        logic tx_complete_flag;
        logic rx_data_full_flag;
        logic rx_overrun_flag;
        logic rx_noise_flag;
        logic rx_framing_error_flag;
        logic rx_idle_flag;
    } sciflg_stat_t;

    // Character delivered by the receive shifter
    typedef struct packed {
        logic             valid;
        logic             noise;
        logic             framing;
        logic [7:0]       data;
    } sciflg_rxchar_t;
endpackage

/* File: sciflg_core.sv */
// Status flags, clear sequence, transmit queue hand-off and interrupt merge
`timescale 1ns/10ps
`default_nettype none
module sciflg_core
    import sciflg_pkg::*;
(
    input  wire logic           REF_CLK,
    input  wire logic           RST,
    input  wire sciflg_ctrl_t   CTRL,
    input  wire logic           STATUS_RD,
    input  wire logic           TX_WR,
    input  wire logic [7:0]     TX_WDATA,
    input  wire logic           RX_RD,
    input  wire logic           BIT_TICK,
    input  wire logic           TX_SHIFT_READY,
    input  wire logic           TX_SHIFT_BUSY,
    input  wire logic           TX_SHIFT_DONE,
    input  wire sciflg_rxchar_t RX_CHAR,
    input  wire logic           RX_LINE,
    output logic                TX_SHIFT_LOAD,
    output logic [7:0]          TX_SHIFT_DATA,
    output logic                TX_PIN_OWN,
    output logic [7:0]          RX_DATA,
    output sciflg_stat_t        STATUS,
    output logic                IRQ
);
    // Sticky flag update; a set in the same cycle beats the clear
    function automatic logic upd(input logic q, input logic set, input logic clr);
        upd = set | (q & ~clr);
    endfunction

    sciflg_stat_t       st_q, st_d;
    sciflg_stat_t       arm_q, arm_d;
    logic [7:0]         txd_q, txd_d;
    logic [7:0]         rxd_q, rxd_d;
    logic               te_q, te_d;
    logic               own_q, own_d;
    logic               irq_q, irq_d;
    logic               busy_q, busy_d;
    logic [IDLE_W-1:0]  icnt_q, icnt_d;
    logic               ln1_q, ln2_q;
    logic               load;
    logic               clr_tx, clr_rx;

    // Hand the queued character to the shifter while enabled
    assign load          = CTRL.tx_enable & ~st_q.tx_data_empty_flag & TX_SHIFT_READY;
    assign TX_SHIFT_LOAD = load;
    assign TX_SHIFT_DATA = txd_q;
    assign TX_PIN_OWN    = own_q;
    assign RX_DATA       = rxd_q;
    assign STATUS        = st_q;
    assign IRQ           = irq_q;

    // Servicing accesses finish a clear sequence armed by a status read
    assign clr_tx = TX_WR;
    assign clr_rx = RX_RD;

    // Next state of the flags, queue, pin ownership and idle detector
    always_comb begin
        logic en_rise;
        logic drop;
        logic rx_new;
        logic ovr;
        en_rise = CTRL.tx_enable & ~te_q;
        drop    = ~CTRL.tx_enable & ~st_q.tx_data_empty_flag;
        rx_new  = RX_CHAR.valid;
        ovr     = rx_new & st_q.rx_data_full_flag & ~(clr_rx & arm_q.rx_data_full_flag);
        te_d    = CTRL.tx_enable;
        txd_d   = txd_q;
        rxd_d   = rxd_q;
        st_d    = st_q;
        arm_d   = arm_q;
        own_d   = own_q;
        busy_d  = busy_q;
        icnt_d  = icnt_q;
        // A status read arms clearing of whichever flags it saw set
        if (STATUS_RD) begin
            arm_d = st_q;
        end
        if (TX_WR) begin
            txd_d = TX_WDATA;
        end
        // Transmit data-empty flag
        st_d.tx_data_empty_flag = upd(st_q.tx_data_empty_flag,
            en_rise | load | (drop & ~TX_SHIFT_BUSY) | (TX_SHIFT_DONE & drop),
            clr_tx & arm_q.tx_data_empty_flag);
        // Transmit complete flag; the end of the last character sets it
        st_d.tx_complete_flag = upd(st_q.tx_complete_flag,
            en_rise | (TX_SHIFT_DONE & (st_q.tx_data_empty_flag | drop))
                | (drop & ~TX_SHIFT_BUSY),
            clr_tx & arm_q.tx_complete_flag);
        // Receive register accepts a character only when the last was read
        if (rx_new && !ovr) begin
            rxd_d = RX_CHAR.data;
            st_d.rx_noise_flag = RX_CHAR.noise;
            st_d.rx_framing_error_flag = RX_CHAR.framing;
        end else if (clr_rx) begin
            st_d.rx_noise_flag = st_q.rx_noise_flag & ~arm_q.rx_noise_flag;
            st_d.rx_framing_error_flag =
                st_q.rx_framing_error_flag & ~arm_q.rx_framing_error_flag;
        end
        st_d.rx_data_full_flag = upd(st_q.rx_data_full_flag, rx_new & ~ovr,
            clr_rx & arm_q.rx_data_full_flag);
        st_d.rx_overrun_flag = upd(st_q.rx_overrun_flag, ovr,
            clr_rx & arm_q.rx_overrun_flag);
        // Idle line: counts high bit times after the line was busy
        if (!ln2_q) begin
            busy_d = 1'b1;
            icnt_d = IDLE_ZERO;
        end else if (BIT_TICK && busy_q) begin
            icnt_d = icnt_q + 4'h1;
            if (icnt_q + 4'h1 == IDLE_BITS) begin
                busy_d = 1'b0;
                icnt_d = IDLE_ZERO;
            end
        end
        st_d.rx_idle_flag = upd(st_q.rx_idle_flag,
            ln2_q & BIT_TICK & busy_q & (icnt_q + 4'h1 == IDLE_BITS),
            clr_rx & arm_q.rx_idle_flag);
        // Pin ownership follows enable or an active shifter on a bit tick
        if (BIT_TICK) begin
            own_d = CTRL.tx_enable | TX_SHIFT_BUSY | load;
        end
        // Single merged request; noise and framing never contribute
        irq_d = (CTRL.tx_empty_irq_mask & st_q.tx_data_empty_flag)
              | (CTRL.tx_complete_irq_mask & st_q.tx_complete_flag)
              | (CTRL.rx_irq_enable & (st_q.rx_data_full_flag | st_q.rx_overrun_flag))
              | (CTRL.idle_irq_enable & st_q.rx_idle_flag);
    end

    // Registers; device reset stops everything at once
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st_q   <= '{TX_DATA_EMPTY_FLAG_RST, TC_RST, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
            arm_q  <= '0;
            txd_q  <= DATA_RST;
            rxd_q  <= DATA_RST;
            te_q   <= 1'b0;
            own_q  <= 1'b0;
            irq_q  <= 1'b0;
            busy_q <= 1'b0;
            icnt_q <= IDLE_ZERO;
        end else begin
            st_q   <= st_d;
            arm_q  <= arm_d;
            txd_q  <= txd_d;
            rxd_q  <= rxd_d;
            te_q   <= te_d;
            own_q  <= own_d;
            irq_q  <= irq_d;
            busy_q <= busy_d;
            icnt_q <= icnt_d;
        end
    end

    // Two-flop synchroniser for the receive pin
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ln1_q <= 1'b1;
            ln2_q <= 1'b1;
        end else begin
            ln1_q <= RX_LINE;
            ln2_q <= ln1_q;
        end
    end

    // Checks
    enable_sets_a: assert property (@(posedge REF_CLK) disable iff (RST)
        CTRL.tx_enable && !te_q |=> st_q.tx_data_empty_flag && st_q.tx_complete_flag)
        else $error("enable did not set transmit flags");
    tx_data_empty_flag_irq_a: assert property (@(posedge REF_CLK) disable iff (RST)
        CTRL.tx_empty_irq_mask && st_q.tx_data_empty_flag |=> IRQ)
        else $error("empty flag request missing");
    tc_irq_a: assert property (@(posedge REF_CLK) disable iff (RST)
        CTRL.tx_complete_irq_mask && st_q.tx_complete_flag |=> IRQ)
        else $error("complete flag request missing");
    no_false_irq_a: assert property (@(posedge REF_CLK) disable iff (RST)
        !CTRL.tx_empty_irq_mask && !CTRL.tx_complete_irq_mask && !CTRL.rx_irq_enable
        && !CTRL.idle_irq_enable |=> !IRQ)
        else $error("request with all enables off");
    clear_needs_arm_a: assert property (@(posedge REF_CLK) disable iff (RST)
        st_q.rx_data_full_flag && !arm_q.rx_data_full_flag |=> st_q.rx_data_full_flag)
        else $error("data-full cleared without status read");
    rx_full_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
        RX_CHAR.valid && !st_q.rx_data_full_flag
        |=> st_q.rx_data_full_flag && RX_DATA == $past(RX_CHAR.data))
        else $error("received character not held");
    overrun_keep_a: assert property (@(posedge REF_CLK) disable iff (RST)
        RX_CHAR.valid && st_q.rx_data_full_flag && !RX_RD
        |=> st_q.rx_overrun_flag && $stable(RX_DATA))
        else $error("overrun handling wrong");
    done_disabled_a: assert property (@(posedge REF_CLK) disable iff (RST)
        TX_SHIFT_DONE && !CTRL.tx_enable
        |=> st_q.tx_complete_flag && st_q.tx_data_empty_flag)
        else $error("last character did not set flags");
    no_load_off_a: assert property (@(posedge REF_CLK) disable iff (RST)
        !CTRL.tx_enable |-> !TX_SHIFT_LOAD)
        else $error("queued character sent after disable");
    pin_kept_a: assert property (@(posedge REF_CLK) disable iff (RST)
        TX_SHIFT_BUSY && own_q |=> own_q)
        else $error("pin released during character");
    idle_once_a: assert property (@(posedge REF_CLK) disable iff (RST)
        !busy_q && ln2_q |=> !$rose(st_q.rx_idle_flag))
        else $error("idle flagged without prior busy line");
    tick_own_a: assert property (@(posedge REF_CLK) disable iff (RST)
        !BIT_TICK |=> $stable(own_q))
        else $error("pin ownership moved off a tick");

    cov_overrun_c: cover property (@(posedge REF_CLK) disable iff (RST)
        $rose(st_q.rx_overrun_flag));
    cov_idle_c: cover property (@(posedge REF_CLK) disable iff (RST)
        $rose(st_q.rx_idle_flag));
    cov_disable_busy_c: cover property (@(posedge REF_CLK) disable iff (RST)
        TX_SHIFT_DONE && !CTRL.tx_enable);
    cov_irq_c: cover property (@(posedge REF_CLK) disable iff (RST) $rose(IRQ));
endmodule
`default_nettype wire

/* File: sciflg_far.sv */
// Model of the transmit shifter and bit-rate tick that face the flag block
`timescale 1ns/10ps
`default_nettype none
module sciflg_far #(
    parameter int SHIFT_CYC = 40
) (
    input  wire logic REF_CLK,
    input  wire logic RST,
    input  wire logic LOAD,
    output logic      READY,
    output logic      BUSY,
    output logic      DONE,
    output logic      TICK
);
    int cnt_q;
    int div_q;
    // A loaded character always shifts to its end, enable or not
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cnt_q <= 0;
            div_q <= 0;
            DONE  <= 1'b0;
        end else begin
            DONE  <= (cnt_q == 1);
            div_q <= (div_q == 3) ? 0 : div_q + 1;
            if (LOAD)
                cnt_q <= SHIFT_CYC;
            else if (cnt_q != 0)
                cnt_q <= cnt_q - 1;
        end
    end
    // Busy while counting, tick every fourth cycle
    assign BUSY  = (cnt_q != 0);
    assign READY = !BUSY;
    assign TICK  = (div_q == 3);
endmodule
`default_nettype wire

/* File: sciflg_core_tb.sv */
// Self-checking bench for the serial status flag block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,a) begin tests_run++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module sci_status_flags_interrupts_tb;
    import sciflg_pkg::*;
    logic         clk  = 1'b0;
    logic         rst  = 1'b1;
    logic         line = 1'b1;
    logic [3:0]   pl   = 4'h0;
    logic [7:0]   wd   = 8'h00;
    logic [9:0]   rxf  = 10'h000;
    sciflg_ctrl_t ctrl = 5'h00;
    sciflg_stat_t st;
    logic         load, pown, irq, rdy, busy, done, tick;
    logic [7:0]   sdat, rdat;
    int           fail_count = 0;
    int           tests_run  = 0;
    int           loads      = 0;
    int           n_ld       = 0;
    int           i;
    // Pulses: 0 status read, 1 tx write, 2 rx read, 3 rx char valid
    sciflg_core i_dut (.REF_CLK(clk), .RST(rst), .CTRL(ctrl), .STATUS_RD(pl[0]), .TX_WR(pl[1]),
        .TX_WDATA(wd), .RX_RD(pl[2]), .BIT_TICK(tick), .TX_SHIFT_READY(rdy), .TX_SHIFT_BUSY(busy),
        .TX_SHIFT_DONE(done), .RX_CHAR({pl[3], rxf}), .RX_LINE(line), .TX_SHIFT_LOAD(load),
        .TX_SHIFT_DATA(sdat), .TX_PIN_OWN(pown), .RX_DATA(rdat), .STATUS(st), .IRQ(irq));
    sciflg_far #(.SHIFT_CYC(40)) i_far (.REF_CLK(clk), .RST(rst), .LOAD(load), .READY(rdy),
        .BUSY(busy), .DONE(done), .TICK(tick));
    // Clock and load counter
    always #5 clk = ~clk;
    always @(posedge clk) if (load === 1'b1) loads++;
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task pulse(input int b);
        @(posedge clk) pl[b] <= 1'b1;
        @(posedge clk) pl[b] <= 1'b0;
        #1;
    endtask
    task wait_done;
        for (i = 0; i < 200 && done !== 1'b1; i++) step(1);
        step(2);
    endtask
    task t_tx;
        @(posedge clk) ctrl.tx_enable <= 1'b1;
        step(3);
        `CHK("tx_flags", 2'b11, {st.tx_data_empty_flag, st.tx_complete_flag})
        `CHK("irq_off", 1'b0, irq)
        @(posedge clk) ctrl.tx_empty_irq_mask <= 1'b1;
        step(3);
        `CHK("irq_tx_data_empty_flag", 1'b1, irq)
        pulse(0);
        @(posedge clk) wd <= 8'h55;
        pulse(1);
        for (i = 0; i < 20 && load !== 1'b1; i++) step(1);
        `CHK("ld_data", 8'h55, sdat)
        `CHK("tc_clr", 1'b0, st.tx_complete_flag)
        step(1);
        `CHK("tx_data_empty_flag_set", 1'b1, st.tx_data_empty_flag)
        @(posedge clk) ctrl <= 5'h14;  // Enable kept, complete mask only
        step(3);
        `CHK("irq_tc0", 1'b0, irq)
        wait_done();
        `CHK("tc_set", 1'b1, st.tx_complete_flag)
        `CHK("irq_tc1", 1'b1, irq)
        @(posedge clk) ctrl.tx_complete_irq_mask <= 1'b0;
    endtask
    task t_dis;
        pulse(0);
        @(posedge clk) wd <= 8'h11;
        pulse(1);
        pulse(0);
        @(posedge clk) wd <= 8'h22;
        pulse(1);
        n_ld = loads;  // Loads seen before the disable
        @(posedge clk) ctrl.tx_enable <= 1'b0;
        step(3);
        `CHK("pin_busy", 1'b1, pown)
        wait_done();
        `CHK("loads", n_ld, loads)
        `CHK("flags_end", 2'b11, {st.tx_data_empty_flag, st.tx_complete_flag})
        step(10);
        `CHK("pin_gpio", 1'b0, pown)
        `CHK("loads2", n_ld, loads)
    endtask
    task t_rx;
        @(posedge clk) begin
            ctrl.rx_irq_enable <= 1'b1;
            rxf <= {2'b10, 8'ha5};
        end
        pulse(3);
        `CHK("full", 1'b1, st.rx_data_full_flag)
        `CHK("rdata", 8'ha5, rdat)
        step(1);
        `CHK("irq_rx", 1'b1, irq)
        @(posedge clk) rxf <= {2'b01, 8'h3c};
        pulse(3);
        `CHK("ovr", 1'b1, st.rx_overrun_flag)
        `CHK("rdata_kept", 8'ha5, rdat)
        `CHK("nf_fe", 2'b10, {st.rx_noise_flag, st.rx_framing_error_flag})
        @(posedge clk) ctrl.rx_irq_enable <= 1'b0;
        step(3);
        `CHK("irq_nf", 1'b0, irq)
        pulse(2);
        `CHK("no_arm", 1'b1, st.rx_data_full_flag)
        pulse(0);
        pulse(2);
        step(1);
        `CHK("rx_clr", 4'h0, st[4:1])
    endtask
    task t_idle;
        @(posedge clk) ctrl.idle_irq_enable <= 1'b1;
        step(60);
        `CHK("idle_never", 1'b0, st.rx_idle_flag)
        @(posedge clk) line <= 1'b0;
        step(8);
        @(posedge clk) line <= 1'b1;
        step(20);
        `CHK("idle_early", 1'b0, st.rx_idle_flag)
        for (i = 0; i < 60 && st.rx_idle_flag !== 1'b1; i++) step(1);
        step(1);
        `CHK("idle_set", 1'b1, st.rx_idle_flag)
        `CHK("irq_idle", 1'b1, irq)
        pulse(0);
        pulse(2);
        step(100);
        `CHK("idle_once", 1'b0, st.rx_idle_flag)
        `CHK("irq_none", 1'b0, irq)
    endtask
    task print_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        step(1);
        `CHK("rst_stat", 7'h60, st)
        t_tx();
        t_dis();
        t_rx();
        t_idle();
        print_verdict();
    end
    // Watchdog well past the expected run length
    initial begin
        #50000;
        fail_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
